// [rtl/analog_pkt_pkg.sv]
package analog_pkt_pkg;
  // channel descriptor word layout
  localparam int DESC_W = 32;
  localparam int RSV_LSB = 29;
  localparam int SAME_POS = 28;
  localparam int FAC_LSB = 24;
  localparam int TOT_LSB = 16;
  localparam int SUB_LSB = 8;
  localparam int LEN_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_PACKED = 2'h0;
  localparam logic [1:0] MODE_LSB_PAD = 2'h1;
  localparam logic [1:0] MODE_RSV = 2'h2;
  localparam logic [1:0] MODE_MSB_PAD = 2'h3;
  // sample output
  localparam int WORD_W = 16;
  localparam int SMP_W = 64;
  localparam logic [2:0] FULL_WORDS = 3'h4;
  localparam logic [8:0] KEY_WRAP = 9'h100;
  // slot table entry layout
  localparam int ENT_SUB_LSB = 0;
  localparam int ENT_FAC_LSB = 8;
  localparam int ENT_LEN_LSB = 12;
  localparam int ENT_W = 18;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TADDR = 8'h0C;
  localparam logic [7:0] REG_TDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_SAME = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_SCHED_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_CNT_LSB = 16;
  // reset values
  localparam logic [1:0] MODE_RST = MODE_MSB_PAD;
  localparam logic [7:0] TOT_RST = 8'h01;
  localparam logic [7:0] SCHED_RST = 8'h00;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_CHK_RD = 10'h002,
    ST_CHK = 10'h004,
    ST_DESC_RD = 10'h008,
    ST_DESC_LO = 10'h010,
    ST_DESC_HI = 10'h020,
    ST_SYNC = 10'h040,
    ST_SMP_RD = 10'h080,
    ST_SMP_REQ = 10'h100,
    ST_SMP_OUT = 10'h200
  } build_state_e;
endpackage : analog_pkt_pkg

// [rtl/slot_table_mem.sv]
`timescale 1ns/1ns
module slot_table_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 256,
  parameter int AW = 8
)(
  input wire logic ref_clk_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // no reset on the array; read data is registered
  always_ff @(posedge ref_clk_in)
  begin
    if (ce_in)
    begin
      if (wr_en_in)
        mem_q[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule : slot_table_mem

// [rtl/analog_sample_packet_builder.sv]
`timescale 1ns/1ns
module analog_sample_packet_builder
  import analog_pkt_pkg::*;
#(
  parameter int SLOTS = 256,
  parameter int SLOT_AW = 8
)(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic smp_sync_out,
  output logic smp_req_out,
  output logic [7:0] smp_subchan_out,
  input wire logic smp_valid_in,
  input wire logic [SMP_W-1:0] smp_data_in,
  output logic [WORD_W-1:0] pkt_data_out,
  output logic pkt_valid_out,
  output logic pkt_desc_out,
  output logic pkt_first_smp_out,
  output logic pkt_last_out,
  input wire logic pkt_ready_in
);
  function automatic logic [8:0] sort_key(input logic [7:0] sub);
    sort_key = (sub == '0) ? KEY_WRAP : {1'b0, sub};
  endfunction : sort_key

  function automatic logic [15:0] span_mask(input logic [3:0] k);
    span_mask = 16'((17'h1 << k) - 17'h1);
  endfunction : span_mask

  function automatic logic hits(input logic [15:0] c, input logic [3:0] k);
    hits = ((16'(c + 16'h1)) & span_mask(k)) == '0;
  endfunction : hits

  function automatic logic [2:0] nwords(input logic [5:0] len);
    logic [6:0] t;
    t = {1'b0, len} + 7'(WORD_W - 1);
    nwords = (len == '0) ? FULL_WORDS : 3'(t >> $clog2(WORD_W));
  endfunction : nwords

  function automatic logic [SMP_W-1:0] pad_sample(input logic [SMP_W-1:0] d,
      input logic [5:0] len, input logic [1:0] mode);
    logic [SMP_W-1:0] m;
    logic [6:0] sh;
    m = (len == '0) ? d : d & ((64'h1 << len) - 64'h1);
    sh = (len == '0) ? 7'h00 :
      7'({4'h0, nwords(len)} << $clog2(WORD_W)) - {1'b0, len};
    pad_sample = (mode == MODE_LSB_PAD) ? (m << sh) : m;
  endfunction : pad_sample

  function automatic logic [DESC_W-1:0] desc_word(input logic same,
      input logic [3:0] fac, input logic [7:0] tot, input logic [7:0] sub,
      input logic [5:0] len, input logic [1:0] mode);
    desc_word = '0;
    desc_word[SAME_POS] = same;
    desc_word[FAC_LSB+:4] = fac;
    desc_word[TOT_LSB+:8] = tot;
    desc_word[SUB_LSB+:8] = same ? 8'h00 : sub;
    desc_word[LEN_LSB+:6] = len;
    desc_word[MODE_LSB+:2] = mode;
  endfunction : desc_word

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      merge[8*b+:8] = sel[b] ? nw[8*b+:8] : old[8*b+:8];
  endfunction : merge

  build_state_e state_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic same_q;
  logic [1:0] mode_q;
  logic [7:0] sched_cfg_q;
  logic [7:0] tot_q;
  logic [SLOT_AW-1:0] taddr_q;
  logic err_q;
  logic [15:0] pkt_cnt_q;
  logic [8:0] idx_q;
  logic [8:0] prev_key_q;
  logic [3:0] maxk_q;
  logic [3:0] fac0_q;
  logic [5:0] len0_q;
  logic [15:0] c_q;
  logic [7:0] sched_q;
  logic [DESC_W-1:0] desc_q;
  logic req_q;
  logic [5:0] len_q;
  logic [SMP_W-1:0] shreg_q;
  logic [2:0] words_q;
  logic first_pend_q;
  logic sync_q;
  logic [WORD_W-1:0] out_data_q;
  logic out_valid_q;
  logic out_desc_q;
  logic out_first_q;
  logic out_last_q;
  logic [8:0] smp_prev_q;
  logic [ENT_W-1:0] ent;
  logic busy;
  logic wr_go;
  logic [31:0] ctrl_img;
  logic [31:0] wval;
  logic start;
  logic tab_we;
  logic [8:0] n_ent;
  logic last_ent;
  logic [3:0] e_fac;
  logic [5:0] e_len;
  logic [7:0] e_sub;
  logic hit;
  logic sched_end;
  logic free;
  logic ld;
  logic [WORD_W-1:0] ld_data;
  logic ld_desc;
  logic ld_first;
  logic ld_last;
  logic [DESC_W-1:0] dw_now;

  assign busy = (state_q != ST_IDLE);
  assign n_ent = (tot_q == '0) ? KEY_WRAP : {1'b0, tot_q};
  assign last_ent = (idx_q == 9'(n_ent - 9'h1));
  assign e_sub = ent[ENT_SUB_LSB+:8];
  assign e_fac = same_q ? fac0_q : ent[ENT_FAC_LSB+:4];
  assign e_len = same_q ? len0_q : ent[ENT_LEN_LSB+:6];
  assign dw_now = desc_word(same_q, e_fac, tot_q, e_sub, e_len,
    mode_q);
  assign hit = hits(c_q, e_fac);
  assign sched_end = (c_q == span_mask(maxk_q));
  assign free = !out_valid_q || pkt_ready_in;

  // wishbone: ack one cycle after the request, write lands on the ack edge
  assign wr_go = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
  assign ctrl_img = 32'({sched_cfg_q, 4'h0, mode_q, same_q, 1'b0});
  assign wval = merge((wb_adr_in == REG_CTRL) ? ctrl_img :
    (wb_adr_in == REG_COUNT) ? {24'h0, tot_q} :
    (wb_adr_in == REG_TADDR) ? 32'(taddr_q) : '0, wb_dat_in, wb_sel_in);
  assign start = wr_go && (wb_adr_in == REG_CTRL) && wval[CTRL_START] &&
    !busy;
  // table writes while building are dropped to keep the packet coherent
  assign tab_we = wr_go && (wb_adr_in == REG_TDATA) && !busy;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end
    else if (ce_in)
    begin
      ack_q <= wb_cyc_in && wb_stb_in && !ack_q;
      if (wb_cyc_in && wb_stb_in && !ack_q)
      begin
        if (wb_adr_in == REG_CTRL)
          rdat_q <= ctrl_img;
        else if (wb_adr_in == REG_COUNT)
          rdat_q <= {24'h0, tot_q};
        else if (wb_adr_in == REG_STATUS)
          rdat_q <= {pkt_cnt_q, 14'h0, err_q, busy};
        else if (wb_adr_in == REG_TADDR)
          rdat_q <= 32'(taddr_q);
        else
          rdat_q <= '0;
      end
    end
  end
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      same_q <= 1'b0;
      mode_q <= MODE_RST;
      sched_cfg_q <= SCHED_RST;
      tot_q <= TOT_RST;
      taddr_q <= '0;
    end
    else if (ce_in && wr_go && !busy)
    begin
      if (wb_adr_in == REG_CTRL)
      begin
        same_q <= wval[CTRL_SAME];
        // one mode per packet; the reserved code is never taken
        if (wval[CTRL_MODE_LSB+:2] != MODE_RSV)
          mode_q <= wval[CTRL_MODE_LSB+:2];
        sched_cfg_q <= wval[CTRL_SCHED_LSB+:8];
      end
      else if (wb_adr_in == REG_COUNT)
        tot_q <= wval[7:0];
      else if (wb_adr_in == REG_TADDR)
        taddr_q <= wval[SLOT_AW-1:0];
      else if (wb_adr_in == REG_TDATA)
        taddr_q <= SLOT_AW'(taddr_q + 1'b1);
    end
  end

  slot_table_mem #(
    .WIDTH(ENT_W),
    .DEPTH(SLOTS),
    .AW(SLOT_AW)
  ) u_table (
    .ref_clk_in(ref_clk_in),
    .ce_in(ce_in),
    .wr_en_in(tab_we),
    .wr_addr_in(taddr_q),
    .wr_data_in(wb_dat_in[ENT_W-1:0]),
    .rd_addr_in(idx_q[SLOT_AW-1:0]),
    .rd_data_out(ent)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      prev_key_q <= '0;
      maxk_q <= '0;
      fac0_q <= '0;
      len0_q <= '0;
      c_q <= '0;
      sched_q <= '0;
      desc_q <= '0;
      req_q <= 1'b0;
      len_q <= '0;
      shreg_q <= '0;
      words_q <= '0;
      err_q <= 1'b0;
      pkt_cnt_q <= '0;
      sync_q <= 1'b0;
    end
    else if (ce_in)
    begin
      sync_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            err_q <= 1'b0;
            idx_q <= '0;
            // the start write carries its own schedule count
            sched_q <= wval[CTRL_SCHED_LSB+:8];
            state_q <= ST_CHK_RD;
          end
        end
        ST_CHK_RD:
          state_q <= ST_CHK;
        ST_CHK:
        begin
          // table must be ascending with subchannel zero last
          if (idx_q == '0)
          begin
            fac0_q <= ent[ENT_FAC_LSB+:4];
            len0_q <= ent[ENT_LEN_LSB+:6];
            maxk_q <= ent[ENT_FAC_LSB+:4];
          end
          else
          begin
            if (sort_key(e_sub) <= prev_key_q)
              err_q <= 1'b1;
            if (e_fac > maxk_q)
              maxk_q <= e_fac;
          end
          prev_key_q <= sort_key(e_sub);
          if (last_ent)
          begin
            idx_q <= '0;
            if (err_q || ((idx_q != '0) && sort_key(e_sub) <= prev_key_q))
              state_q <= ST_IDLE;
            else
              state_q <= ST_DESC_RD;
          end
          else
          begin
            idx_q <= 9'(idx_q + 9'h1);
            state_q <= ST_CHK_RD;
          end
        end
        ST_DESC_RD:
          state_q <= ST_DESC_LO;
        ST_DESC_LO:
        begin
          desc_q <= dw_now;
          if (free)
            state_q <= ST_DESC_HI;
        end
        ST_DESC_HI:
        begin
          if (free)
          begin
            // a shared descriptor stands for every subchannel
            if (same_q || last_ent)
            begin
              idx_q <= '0;
              c_q <= '0;
              state_q <= ST_SYNC;
            end
            else
            begin
              idx_q <= 9'(idx_q + 9'h1);
              state_q <= ST_DESC_RD;
            end
          end
        end
        ST_SYNC:
        begin
          sync_q <= 1'b1;
          idx_q <= '0;
          state_q <= ST_SMP_RD;
        end
        ST_SMP_RD:
          state_q <= ST_SMP_REQ;
        ST_SMP_REQ:
        begin
          if (!req_q && hit)
          begin
            req_q <= 1'b1;
            len_q <= e_len;
          end
          else if (req_q && smp_valid_in)
          begin
            req_q <= 1'b0;
            shreg_q <= pad_sample(smp_data_in, len_q, mode_q);
            words_q <= nwords(len_q);
            state_q <= ST_SMP_OUT;
          end
          else if (!req_q)
          begin
            if (last_ent)
            begin
              idx_q <= '0;
              c_q <= sched_end ? '0 : 16'(c_q + 16'h1);
              state_q <= (sched_end && sched_q == '0) ? ST_IDLE : ST_SYNC;
              if (sched_end && sched_q != '0)
                sched_q <= 8'(sched_q - 8'h1);
              if (sched_end && sched_q == '0)
                pkt_cnt_q <= 16'(pkt_cnt_q + 16'h1);
            end
            else
            begin
              idx_q <= 9'(idx_q + 9'h1);
              state_q <= ST_SMP_RD;
            end
          end
        end
        ST_SMP_OUT:
        begin
          if (free)
          begin
            shreg_q <= shreg_q >> WORD_W;
            words_q <= 3'(words_q - 3'h1);
            if (words_q == 3'h1 && last_ent)
            begin
              idx_q <= '0;
              c_q <= sched_end ? '0 : 16'(c_q + 16'h1);
              state_q <= (sched_end && sched_q == '0) ? ST_IDLE : ST_SYNC;
              if (sched_end && sched_q != '0)
                sched_q <= 8'(sched_q - 8'h1);
              if (sched_end && sched_q == '0)
                pkt_cnt_q <= 16'(pkt_cnt_q + 16'h1);
            end
            else if (words_q == 3'h1)
            begin
              idx_q <= 9'(idx_q + 9'h1);
              state_q <= ST_SMP_RD;
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // output word selection; descriptors go low half first
  always_comb
  begin
    ld = 1'b0;
    ld_data = '0;
    ld_desc = 1'b0;
    ld_first = 1'b0;
    ld_last = 1'b0;
    if (free && state_q == ST_DESC_HI)
    begin
      ld = 1'b1;
      ld_data = desc_q[WORD_W+:WORD_W];
      ld_desc = 1'b1;
    end
    else if (free && state_q == ST_DESC_LO)
    begin
      ld = 1'b1;
      ld_data = dw_now[WORD_W-1:0];
      ld_desc = 1'b1;
    end
    else if (free && state_q == ST_SMP_OUT)
    begin
      ld = 1'b1;
      ld_data = shreg_q[WORD_W-1:0];
      ld_first = first_pend_q;
      ld_last = (words_q == 3'h1) && last_ent && sched_end &&
        (sched_q == '0);
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      out_desc_q <= 1'b0;
      out_first_q <= 1'b0;
      out_last_q <= 1'b0;
      first_pend_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start)
        first_pend_q <= 1'b1;
      else if (ld && ld_first)
        first_pend_q <= 1'b0;
      if (ld)
      begin
        out_valid_q <= 1'b1;
        out_data_q <= ld_data;
        out_desc_q <= ld_desc;
        out_first_q <= ld_first;
        out_last_q <= ld_last;
      end
      else if (pkt_ready_in)
        out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      smp_prev_q <= '0;
    else if (ce_in && sync_q)
      smp_prev_q <= '0;
    else if (ce_in && req_q && smp_valid_in)
      smp_prev_q <= sort_key(e_sub);
  end

  assign smp_sync_out = sync_q;
  assign smp_req_out = req_q;
  assign smp_subchan_out = e_sub;
  assign pkt_data_out = out_data_q;
  assign pkt_valid_out = out_valid_q;
  assign pkt_desc_out = out_desc_q;
  assign pkt_first_smp_out = out_first_q;
  assign pkt_last_out = out_last_q;

  AST_RSV_ZERO:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && ld && state_q == ST_DESC_HI) |=>
    pkt_data_out[WORD_W-1:RSV_LSB-WORD_W] == '0)
  else $error("reserved descriptor bits not zero");

  AST_MODE_LEGAL:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && ld && state_q == ST_DESC_LO) |=>
    pkt_desc_out && pkt_data_out[MODE_LSB+:2] != MODE_RSV)
  else $error("reserved packing mode emitted");

  AST_SHARED_SUB:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && ld && state_q == ST_DESC_LO && same_q) |=>
    pkt_data_out[SUB_LSB+:8] == '0 && pkt_data_out[MODE_LSB+:2] == mode_q)
  else $error("shared descriptor with nonzero subchannel");

  AST_TOTAL:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && ld && state_q == ST_DESC_HI) |=>
    pkt_data_out[TOT_LSB-WORD_W+:8] == tot_q)
  else $error("descriptor total differs from count register");

  AST_DESC_FIRST:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && state_q == ST_SYNC) |-> !first_pend_q ||
    (out_desc_q && out_valid_q) || $past(out_desc_q))
  else $error("sampling began before descriptors");

  AST_SYNC_PULSE:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && smp_sync_out) |=> !smp_sync_out ##1 !smp_sync_out)
  else $error("sync strobe longer than one cycle");

  AST_ASCEND:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ce_in && req_q && smp_valid_in) |-> sort_key(e_sub) > smp_prev_q)
  else $error("samples out of subchannel order");

  AST_LAST_ALL:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_q == ST_SMP_REQ && !req_q && sched_end) |-> hit)
  else $error("subchannel missing from last simultaneous sample");

  AST_HOLD:
  assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (pkt_valid_out && !pkt_ready_in) |=>
    pkt_valid_out && $stable(pkt_data_out))
  else $error("output word dropped under back-pressure");
endmodule : analog_sample_packet_builder

// [tb/analog_front_model.sv]
`timescale 1ns/1ns
module analog_front_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sync_in,
  input wire logic req_in,
  input wire logic [7:0] sub_in,
  output logic valid_out,
  output logic [63:0] data_out
);
  logic [7:0] nsync_q;
  logic [3:0] rnd_q;
  // random wait so the builder has to hold its request
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      nsync_q <= 8'h00;
      rnd_q <= 4'h9;
      valid_out <= 1'b0;
      data_out <= 64'h0;
    end
    else
    begin
      rnd_q <= {rnd_q[2:0], rnd_q[3] ^ rnd_q[2]};
      if (sync_in)
        nsync_q <= nsync_q + 8'h01;
      if (valid_out)
      begin
        valid_out <= 1'b0;
        // released bus shows no stale sample
        data_out <= ~data_out;
      end
      else if (req_in && rnd_q[1:0] == 2'h0)
      begin
        valid_out <= 1'b1;
        data_out <= {8{sub_in ^ nsync_q}} ^ 64'hC3A5_5A3C_0F1E_E1F0;
      end
    end
  end
endmodule : analog_front_model

// [tb/analog_sample_packet_builder_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("mismatch at %0t got %h exp %h", $time, g, e); \
    end \
  end
module analog_sample_packet_builder_tb;
  import analog_pkt_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ready = 1'b0;
  logic ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd_o;
  logic [31:0] rdat;
  logic ack, sync, req, valid, pvalid, pdesc, pfirst, plast;
  logic [7:0] sub;
  logic [63:0] sdata;
  logic [15:0] pdata;
  logic [31:0] rnd = 32'h8824;
  logic [31:0] rq = 32'h8824;
  logic [18:0] exp_w;
  logic [18:0] exp_q[$];
  logic [7:0] t_sub[4];
  logic [3:0] t_fac[4];
  logic [5:0] t_len[4];
  logic [1:0] modes[3] = '{MODE_PACKED, MODE_LSB_PAD, MODE_MSB_PAD};
  int err_total = 0;
  int num_checks = 0;
  int s_cnt = 0;

  always #2 ref_clk_in = ~ref_clk_in;

  analog_sample_packet_builder i_dut (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(rd_o), .wb_ack_out(ack), .smp_sync_out(sync),
    .smp_req_out(req), .smp_subchan_out(sub), .smp_valid_in(valid),
    .smp_data_in(sdata), .pkt_data_out(pdata), .pkt_valid_out(pvalid),
    .pkt_desc_out(pdesc), .pkt_first_smp_out(pfirst),
    .pkt_last_out(plast), .pkt_ready_in(ready));

  analog_front_model i_front (.clk_in(ref_clk_in), .rstn_in(rstn_in),
    .sync_in(sync), .req_in(req), .sub_in(sub), .valid_out(valid),
    .data_out(sdata));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // recording path stalls at random
  always @(posedge ref_clk_in)
  begin
    rq = lfsr(rq);
    ready <= rq[2] | rq[7];
    if (pvalid === 1'b1 && ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(pvalid, 1'b0)
      else
      begin
        exp_w = exp_q.pop_front();
        `CHK({plast, pfirst, pdesc}, exp_w[18:16])
        `CHK(pdata, exp_w[15:0])
      end
    end
  end

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = rd_o;
    cyc <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : wb

  task automatic put_smp(input logic [7:0] sb, input logic [5:0] ln,
                         input logic [1:0] md, input logic fst);
    logic [63:0] v;
    int w;
    int nw;
    w = (ln == 6'h00) ? 64 : ln;
    nw = (w + 15) / 16;
    v = {8{sb ^ s_cnt[7:0]}} ^ 64'hC3A5_5A3C_0F1E_E1F0;
    if (w < 64)
      v = v & ((64'h1 << w) - 64'h1);
    if (md == MODE_LSB_PAD)
      v = v << (nw * 16 - w);
    for (int i = 0; i < nw; i++)
      exp_q.push_back({1'b0, fst && i == 0, 1'b0, v[16*i +: 16]});
  endtask : put_smp

  task automatic run_pkt(input logic same, input logic [1:0] md,
                         input logic [7:0] ex, input int n, input logic bad);
    int mk, k, m;
    logic fst;
    logic [31:0] st0;
    logic [31:0] dw;
    wb(1'b0, REG_STATUS, 32'h0);
    st0 = rdat;
    wb(1'b1, REG_COUNT, 32'(n));
    wb(1'b1, REG_TADDR, 32'h0);
    for (int i = 0; i < n; i++)
      wb(1'b1, REG_TDATA, {14'h0, t_len[i], t_fac[i], t_sub[i]});
    mk = 0;
    fst = 1'b1;
    for (int i = 0; i < (same ? 1 : n) && !bad; i++)
    begin
      dw = {3'h0, same, t_fac[i], 8'(n), same ? 8'h00 : t_sub[i],
            t_len[i], md};
      exp_q.push_back({3'h1, dw[15:0]});
      exp_q.push_back({3'h1, dw[31:16]});
      if (t_fac[i] > mk)
        mk = t_fac[i];
    end
    for (int c = 0; c <= ex && !bad; c++)
      for (int j = 1; j <= (1 << mk); j++)
      begin
        s_cnt++;
        for (int i = 0; i < n; i++)
        begin
          k = same ? t_fac[0] : t_fac[i];
          if (j % (1 << k) == 0)
          begin
            put_smp(t_sub[i], same ? t_len[0] : t_len[i], md, fst);
            fst = 1'b0;
          end
        end
      end
    if (!bad)
      exp_q[$][18] = 1'b1;
    wb(1'b1, REG_CTRL, {16'h0, ex, 4'h0, md, same, 1'b1});
    m = 0;
    do
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      m++;
    end
    while ((rdat[STAT_BUSY] !== 1'b0 || exp_q.size() != 0) && m < 3000);
    if (m >= 3000)
    begin
      err_total++;
      report_and_stop();
    end
    `CHK(exp_q.size(), 0)
    `CHK(rdat[STAT_ERR], bad)
    `CHK(rdat[31:16], st0[31:16] + {15'h0, !bad})
  endtask : run_pkt

  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(rdat, 32'h0000_000C)
    wb(1'b0, REG_COUNT, 32'h0);
    `CHK(rdat, 32'h0000_0001)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rdat, 32'h0)
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rdat, 32'h0)
    // a frozen block must neither answer nor store a held write
    @(posedge ref_clk_in);
    ce <= 1'b0;
    cyc <= 1'b1;
    we <= 1'b1;
    adr <= REG_COUNT;
    wdat <= 32'h0000_0077;
    repeat (4) @(posedge ref_clk_in);
    `CHK(ack, 1'b0)
    cyc <= 1'b0;
    we <= 1'b0;
    ce <= 1'b1;
    wb(1'b0, REG_COUNT, 32'h0);
    `CHK(rdat, 32'h0000_0001)
    // reserved packing code must not be stored
    wb(1'b1, REG_CTRL, 32'h0000_0008);
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(rdat[3:2], MODE_MSB_PAD)
    // single channel in both encodings
    t_sub[0] = 8'h01;
    t_fac[0] = 4'h0;
    t_len[0] = 6'h0C;
    run_pkt(1'b1, MODE_MSB_PAD, 8'h00, 1, 1'b0);
    run_pkt(1'b0, MODE_LSB_PAD, 8'h00, 1, 1'b0);
    // subchannel 256 goes last with 64-bit samples, subchannel 3 with 12-bit
    t_sub[0] = 8'h03;
    t_sub[1] = 8'h00;
    t_fac[0] = 4'h0;
    t_fac[1] = 4'h1;
    t_len[0] = 6'h0C;
    t_len[1] = 6'h00;
    run_pkt(1'b0, MODE_MSB_PAD, 8'h01, 2, 1'b0);
    // descending table is refused
    t_sub[0] = 8'h05;
    t_sub[1] = 8'h03;
    run_pkt(1'b0, MODE_MSB_PAD, 8'h00, 2, 1'b1);
    for (int p = 0; p < 6; p++)
    begin
      rnd = lfsr(rnd);
      t_sub[0] = 8'(1 + rnd[1:0]);
      for (int i = 0; i < 4; i++)
      begin
        rnd = lfsr(rnd);
        if (i > 0)
          t_sub[i] = t_sub[i-1] + 8'(1 + rnd[2:1]);
        t_fac[i] = 4'(rnd[9:8] % 3);
        t_len[i] = rnd[15:10];
      end
      run_pkt(p[0], modes[p%3], 8'(p%2), 1 + rnd[5:4], 1'b0);
    end
    report_and_stop();
  end
endmodule : analog_sample_packet_builder_tb
